// [rtl/nand_boot_pkg.sv]
// Constants and types shared by the NAND boot block search sequencer
// Notes on behaviour
// - Pages are read as 512-byte user segments, each with its stored spare-area ECC.
// - Syndrome from stored ECC and port parity; up to four bit errors corrected.
// - Any error located in stored ECC data fails the segment, whatever the count.
// - Block marked bad in spare area is skipped without reading its pages.
// - First read of a good block is its page zero.
// - Page zero failure skips to the next block instead of aborting.
// - Only the first thirty-two blocks are searched; all failing reports boot failure.
// - After a usable page zero, the remaining pages of that block are read.
// - Failure on a later page stops with boot error, no other block tried.
package nand_boot_pkg;
    localparam int SEG_BYTES = 512;
    localparam int SEG_AW = 9;
    localparam int MAX_BIT_ERR = 4;
    localparam int MAX_BLOCKS = 32;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int SEGS_PER_PAGE = 4;
    localparam int ECC_BITS = 80;
    localparam int LOC_POS_W = 10;
    localparam int LOC_W = LOC_POS_W + 3;
    localparam int LOC_SLOTS = 4;
    localparam logic [LOC_POS_W-1:0] ECC_AREA_BASE = 10'h200;

    typedef enum logic [3:0] {
        S_MARK_REQ,
        S_MARK_WAIT,
        S_SEG_REQ,
        S_SEG_FILL,
        S_LOC_WAIT,
        S_DRAIN,
        S_DONE,
        S_FAIL,
        S_ERROR
    } seq_state_t;
endpackage : nand_boot_pkg

// [rtl/seg_buf_if.sv]
// Interface between the sequencer and its segment buffer
`timescale 1ns/1ps
interface seg_buf_if #(
    parameter int AW = 9
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;

    modport owner (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : seg_buf_if

// [rtl/seg_buffer.sv]
// One-segment byte buffer with registered read data
`timescale 1ns/1ps
module seg_buffer #(
    parameter int DEPTH = 512
) (
    input wire logic sys_clk_i,
    seg_buf_if.mem bus
);
    logic [7:0] mem_q [DEPTH];

    // Plain synchronous RAM; no reset so it maps onto block memory
    always_ff @(posedge sys_clk_i)
    begin
        if (bus.wr_en)
        begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        if (bus.rd_en)
        begin
            bus.rd_data <= mem_q[bus.rd_addr];
        end
    end
endmodule : seg_buffer

// [rtl/nand_boot_search.sv]
// Boot-time NAND block search, segment check, correction and streaming
`timescale 1ns/1ps
module nand_boot_search #(
    parameter int MAX_BLOCKS = nand_boot_pkg::MAX_BLOCKS,
    parameter int PAGES_PER_BLOCK = nand_boot_pkg::PAGES_PER_BLOCK,
    parameter int SEGS_PER_PAGE = nand_boot_pkg::SEGS_PER_PAGE
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    output logic mem_req_o,
    output logic mem_mark_o,
    output logic [5:0] mem_block_o,
    output logic [5:0] mem_page_o,
    output logic [1:0] mem_seg_o,
    input wire logic mem_data_valid_i,
    input wire logic [7:0] mem_data_i,
    input wire logic mem_done_i,
    input wire logic mem_bad_i,
    input wire logic [nand_boot_pkg::ECC_BITS-1:0] mem_parity_i,
    input wire logic [nand_boot_pkg::ECC_BITS-1:0] mem_ecc_i,
    output logic syndrome_valid_o,
    output logic [nand_boot_pkg::ECC_BITS-1:0] syndrome_o,
    input wire logic loc_valid_i,
    input wire logic loc_uncorrectable_i,
    input wire logic [2:0] loc_count_i,
    input wire logic [nand_boot_pkg::LOC_SLOTS*nand_boot_pkg::LOC_W-1:0] loc_list_i,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic boot_done_o,
    output logic boot_fail_o,
    output logic boot_error_o
);
    localparam int AW = nand_boot_pkg::SEG_AW;
    localparam int LW = nand_boot_pkg::LOC_W;
    localparam int PW = nand_boot_pkg::LOC_POS_W;

    seg_buf_if #(.AW(AW)) buf_bus ();

    seg_buffer #(.DEPTH(nand_boot_pkg::SEG_BYTES)) u_buf (
        .sys_clk_i(sys_clk_i),
        .bus(buf_bus.mem)
    );

    nand_boot_pkg::seq_state_t state, next_state;
    logic [5:0] block, next_block;
    logic [5:0] page, next_page;
    logic [1:0] seg, next_seg;
    logic [AW:0] wr_idx, next_wr_idx;
    logic [AW:0] rd_idx, next_rd_idx;
    logic rd_pend, next_rd_pend;
    logic [AW-1:0] rd_addr_q, next_rd_addr_q;
    logic [LW*nand_boot_pkg::LOC_SLOTS-1:0] locs, next_locs;
    logic [2:0] loc_cnt, next_loc_cnt;
    logic next_mem_req, next_mem_mark, next_syn_valid, next_out_valid;
    logic [nand_boot_pkg::ECC_BITS-1:0] next_syndrome;
    logic [7:0] next_out_data;
    logic next_done, next_fail, next_error;
    logic seg_bad;
    logic [7:0] fix_mask;
    logic [nand_boot_pkg::LOC_SLOTS-1:0] slot_in_ecc;
    logic [nand_boot_pkg::LOC_SLOTS-1:0] slot_hit;

    // Per-slot decode of the locator list: ECC-area hits and drain-address matches
    genvar gi;
    generate
        for (gi = 0; gi < nand_boot_pkg::LOC_SLOTS; gi++)
        begin : g_slot
            logic [PW-1:0] in_pos;
            logic [PW-1:0] held_pos;
            assign in_pos = loc_list_i[gi*LW+3 +: PW];
            assign held_pos = locs[gi*LW+3 +: PW];
            assign slot_in_ecc[gi] = (3'(gi) < loc_count_i)
                && (in_pos >= nand_boot_pkg::ECC_AREA_BASE);
            assign slot_hit[gi] = (3'(gi) < loc_cnt)
                && (held_pos == {1'b0, rd_addr_q});
        end
    endgenerate

    // A segment fails on an uncorrectable verdict, too many bits, or any ECC-area hit
    assign seg_bad = loc_uncorrectable_i
        || (loc_count_i > 3'(nand_boot_pkg::MAX_BIT_ERR))
        || (|slot_in_ecc);

    // Flip mask for the byte now leaving the buffer
    always_comb
    begin
        fix_mask = 8'h00;
        for (int i = 0; i < nand_boot_pkg::LOC_SLOTS; i++)
        begin
            if (slot_hit[i])
            begin
                fix_mask = fix_mask ^ (8'h01 << locs[i*LW +: 3]);
            end
        end
    end

    // Buffer port drive: writes while filling, reads while draining
    assign buf_bus.wr_en = (state == nand_boot_pkg::S_SEG_FILL) && mem_data_valid_i
        && (wr_idx < (AW+1)'(nand_boot_pkg::SEG_BYTES));
    assign buf_bus.wr_addr = wr_idx[AW-1:0];
    assign buf_bus.wr_data = mem_data_i;
    assign buf_bus.rd_en = (state == nand_boot_pkg::S_DRAIN)
        && (rd_idx < (AW+1)'(nand_boot_pkg::SEG_BYTES));
    assign buf_bus.rd_addr = rd_idx[AW-1:0];

    // Sequencer next-state; a skip and the block limit share one path
    always_comb
    begin
        next_state = state;
        next_block = block;
        next_page = page;
        next_seg = seg;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_rd_pend = buf_bus.rd_en;
        next_rd_addr_q = buf_bus.rd_addr;
        next_locs = locs;
        next_loc_cnt = loc_cnt;
        next_mem_req = 1'b0;
        next_mem_mark = mem_mark_o;
        next_syn_valid = 1'b0;
        next_syndrome = syndrome_o;
        next_out_valid = rd_pend;
        next_out_data = rd_pend ? (buf_bus.rd_data ^ fix_mask) : out_data_o;
        next_done = boot_done_o;
        next_fail = boot_fail_o;
        next_error = boot_error_o;
        if (buf_bus.wr_en)
        begin
            next_wr_idx = wr_idx + 1'b1;
        end
        unique case (state)
            nand_boot_pkg::S_MARK_REQ:
            begin
                next_mem_req = 1'b1;
                next_mem_mark = 1'b1;
                next_state = nand_boot_pkg::S_MARK_WAIT;
            end
            nand_boot_pkg::S_MARK_WAIT:
            begin
                if (mem_done_i && mem_bad_i)
                begin
                    next_block = block + 1'b1;
                    next_state = (block + 1'b1 == 6'(MAX_BLOCKS)) ?
                        nand_boot_pkg::S_FAIL : nand_boot_pkg::S_MARK_REQ;
                end
                else if (mem_done_i)
                begin
                    next_page = 6'h00;
                    next_seg = 2'h0;
                    next_state = nand_boot_pkg::S_SEG_REQ;
                end
            end
            nand_boot_pkg::S_SEG_REQ:
            begin
                next_mem_req = 1'b1;
                next_mem_mark = 1'b0;
                next_wr_idx = '0;
                next_state = nand_boot_pkg::S_SEG_FILL;
            end
            nand_boot_pkg::S_SEG_FILL:
            begin
                if (mem_done_i)
                begin
                    next_syndrome = mem_parity_i ^ mem_ecc_i;
                    next_syn_valid = 1'b1;
                    next_state = nand_boot_pkg::S_LOC_WAIT;
                end
            end
            nand_boot_pkg::S_LOC_WAIT:
            begin
                if (loc_valid_i && seg_bad && (page == 6'h00))
                begin
                    next_block = block + 1'b1;
                    next_state = (block + 1'b1 == 6'(MAX_BLOCKS)) ?
                        nand_boot_pkg::S_FAIL : nand_boot_pkg::S_MARK_REQ;
                end
                else if (loc_valid_i && seg_bad)
                begin
                    next_state = nand_boot_pkg::S_ERROR;
                end
                else if (loc_valid_i)
                begin
                    next_locs = loc_list_i;
                    next_loc_cnt = loc_count_i;
                    next_rd_idx = '0;
                    next_state = nand_boot_pkg::S_DRAIN;
                end
            end
            nand_boot_pkg::S_DRAIN:
            begin
                if (buf_bus.rd_en)
                begin
                    next_rd_idx = rd_idx + 1'b1;
                end
                else if (!rd_pend)
                begin
                    // Segment fully streamed; step segment then page upward
                    next_state = nand_boot_pkg::S_SEG_REQ;
                    next_seg = seg + 1'b1;
                    if (seg == 2'(SEGS_PER_PAGE - 1))
                    begin
                        next_seg = 2'h0;
                        next_page = page + 1'b1;
                        if (page == 6'(PAGES_PER_BLOCK - 1))
                        begin
                            next_state = nand_boot_pkg::S_DONE;
                        end
                    end
                end
            end
            nand_boot_pkg::S_DONE:
            begin
                next_done = 1'b1;
            end
            nand_boot_pkg::S_FAIL:
            begin
                next_fail = 1'b1;
            end
            nand_boot_pkg::S_ERROR:
            begin
                next_error = 1'b1;
            end
        endcase
    end

    // State and output registers; search starts at block zero on reset release
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= nand_boot_pkg::S_MARK_REQ;
            block <= 6'h00;
            page <= 6'h00;
            seg <= 2'h0;
            wr_idx <= '0;
            rd_idx <= '0;
            rd_pend <= 1'b0;
            rd_addr_q <= '0;
            locs <= '0;
            loc_cnt <= 3'h0;
            mem_req_o <= 1'b0;
            mem_mark_o <= 1'b0;
            syndrome_valid_o <= 1'b0;
            syndrome_o <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
            boot_done_o <= 1'b0;
            boot_fail_o <= 1'b0;
            boot_error_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            block <= next_block;
            page <= next_page;
            seg <= next_seg;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            rd_pend <= next_rd_pend;
            rd_addr_q <= next_rd_addr_q;
            locs <= next_locs;
            loc_cnt <= next_loc_cnt;
            mem_req_o <= next_mem_req;
            mem_mark_o <= next_mem_mark;
            syndrome_valid_o <= next_syn_valid;
            syndrome_o <= next_syndrome;
            out_valid_o <= next_out_valid;
            out_data_o <= next_out_data;
            boot_done_o <= next_done;
            boot_fail_o <= next_fail;
            boot_error_o <= next_error;
        end
    end

    // Address outputs mirror the counters so they stand for the whole request
    assign mem_block_o = block;
    assign mem_page_o = page;
    assign mem_seg_o = seg;

    // Length of the current output run; a counter stands in for a long fixed delay
    logic [9:0] run_len;
    logic [9:0] next_run_len;

    always_comb
    begin
        next_run_len = out_valid_o ? (run_len + 10'h001) : 10'h000;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            run_len <= 10'h000;
        end
        else
        begin
            run_len <= next_run_len;
        end
    end

    // Checks
    sequence s_bad_seg;
        (state == nand_boot_pkg::S_LOC_WAIT) && loc_valid_i && seg_bad;
    endsequence

    property p_bad_mark_skip;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state == nand_boot_pkg::S_MARK_WAIT) && mem_done_i && mem_bad_i
            && (block < 6'(MAX_BLOCKS - 1))
        |=> (block == $past(block) + 6'h01) ##1 (mem_req_o && mem_mark_o);
    endproperty
    a_bad_mark_skip: assert property (p_bad_mark_skip) else $error("bad block not skipped");

    property p_page0_first;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state == nand_boot_pkg::S_MARK_WAIT) && mem_done_i && !mem_bad_i
        |=> ##1 (mem_req_o && !mem_mark_o && page == 6'h00 && seg == 2'h0);
    endproperty
    a_page0_first: assert property (p_page0_first) else $error("good block not opened at page 0");

    property p_ecc_hit_fails;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state == nand_boot_pkg::S_LOC_WAIT) && loc_valid_i && (|slot_in_ecc)
        |=> (state != nand_boot_pkg::S_DRAIN);
    endproperty
    a_ecc_hit_fails: assert property (p_ecc_hit_fails) else $error("ECC-area error accepted");

    property p_page0_skip;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_bad_seg and (page == 6'h00) |=> !boot_error_o ##0 block == $past(block) + 6'h01;
    endproperty
    a_page0_skip: assert property (p_page0_skip) else $error("page 0 failure did not skip");

    property p_later_error;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_bad_seg and (page != 6'h00) |=> ##1 boot_error_o ##1 (boot_error_o && !mem_req_o);
    endproperty
    a_later_error: assert property (p_later_error) else $error("later page failure not fatal");

    property p_block_limit;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mem_req_o |-> (block < 6'(MAX_BLOCKS));
    endproperty
    a_block_limit: assert property (p_block_limit) else $error("searched beyond block limit");

    property p_syndrome;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state == nand_boot_pkg::S_SEG_FILL) && mem_done_i
        |=> syndrome_valid_o && (syndrome_o == ($past(mem_parity_i) ^ $past(mem_ecc_i)));
    endproperty
    a_syndrome: assert property (p_syndrome) else $error("syndrome wrong");

    property p_stream_len;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(state == nand_boot_pkg::S_DRAIN) |-> ##2 (out_valid_o && run_len == 10'h000);
    endproperty
    a_stream_len: assert property (p_stream_len) else $error("segment stream late");

    property p_stream_end;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(out_valid_o) |-> (run_len == 10'(nand_boot_pkg::SEG_BYTES));
    endproperty
    a_stream_end: assert property (p_stream_end) else $error("segment not 512 bytes");

    property p_page_order;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $changed(page) && (state != nand_boot_pkg::S_MARK_WAIT)
        |-> (page == $past(page) + 6'h01) && (block == $past(block));
    endproperty
    a_page_order: assert property (p_page_order) else $error("pages not in order");
endmodule : nand_boot_search

// [bench/nand_flash_model.sv]
// Behavioural NAND flash and error locator facing the boot search block
`timescale 1ns/1ps
module nand_flash_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic mark_i,
    input wire logic [5:0] blk_i,
    input wire logic [5:0] pg_i,
    input wire logic [1:0] seg_i,
    input wire logic syn_i,
    output logic dv_o,
    output logic [7:0] d_o,
    output logic done_o,
    output logic bad_o,
    output logic [79:0] par_o,
    output logic [79:0] ecc_o,
    output logic lv_o,
    output logic lu_o,
    output logic [2:0] lc_o,
    output logic [51:0] ll_o
);
    // Stored ECC value is arbitrary; parity differs from it by block, page and segment
    localparam logic [79:0] ECC_STORED = 80'h5a5a_0f0f_3c3c_1234_abcd;
    logic [31:0] bad_mark;
    logic [2:0] verdict [32][2];
    logic slow;
    logic [5:0] blk;
    logic [5:0] pg;
    logic [1:0] sg;
    logic mk;
    logic [2:0] code;
    int n;

    function automatic logic [7:0] pat(input logic [5:0] b, input logic [5:0] p,
        input logic [1:0] s, input int i);
        return i[7:0] + {b[4:0], 3'h0} + {2'h0, p} + {6'h0, s};
    endfunction : pat

    // Codes: 1 one flip, 2 flip in ECC area, 3 uncorrectable, 4 five errors, 5 four flips
    function automatic logic [7:0] flip(input logic [2:0] c, input int i);
        if (c == 3'h1 && i == 5)
            return 8'h04;
        if (c == 3'h5 && (i == 0 || i == 1 || i == 100 || i == 511))
            return 8'h02;
        return 8'h00;
    endfunction : flip

    // Packs uncorrectable flag, error count and slot list
    function automatic logic [55:0] word(input logic [2:0] c);
        case (c)
            3'h1: return {4'h1, 39'h0, 10'h005, 3'h2};
            3'h2: return {4'h1, 39'h0, 10'h203, 3'h0};
            3'h3: return {4'h8, 52'h0};
            3'h4: return {4'h5, {4{10'h007, 3'h0}}};
            3'h5: return {4'h4, 10'h1ff, 3'h1, 10'h064, 3'h1, 10'h001, 3'h1, 10'h000, 3'h1};
            default: return 56'h0;
        endcase
    endfunction : word

    initial
    begin
        bad_mark = 32'h0;
        slow = 1'b0;
        {dv_o, done_o, bad_o, lv_o, lu_o, lc_o} = 8'h0;
        {d_o, par_o, ecc_o, ll_o} = '0;
    end

    // One request at a time; a segment read is followed by one locator verdict
    always
    begin : serve
        @(posedge clk_i);
        if (req_i === 1'b1)
        begin
            blk = blk_i;
            pg = pg_i;
            sg = seg_i;
            mk = mark_i;
            code = verdict[blk[4:0]][pg[0]];
            repeat (slow ? 6 : 1) @(negedge clk_i);
            for (n = 0; n < 512 && !mk; n++)
            begin
                @(negedge clk_i);
                dv_o <= 1'b1;
                d_o <= pat(blk, pg, sg, n) ^ flip(code, n);
            end
            @(negedge clk_i);
            dv_o <= 1'b0;
            d_o <= ~d_o;
            done_o <= 1'b1;
            bad_o <= bad_mark[blk[4:0]];
            par_o <= {blk, pg, sg, 66'h0} ^ ECC_STORED;
            ecc_o <= ECC_STORED;
            @(negedge clk_i);
            // Released lines show garbage, never the last value
            done_o <= 1'b0;
            bad_o <= ~bad_o;
            par_o <= ~par_o;
            ecc_o <= ~ecc_o;
            for (n = 0; n < 20 && !mk && syn_i !== 1'b1; n++)
                @(posedge clk_i);
            if (!mk)
            begin
                repeat (slow ? 9 : 1) @(negedge clk_i);
                lv_o <= 1'b1;
                {lu_o, lc_o, ll_o} <= word(code);
                @(negedge clk_i);
                lv_o <= 1'b0;
                {lu_o, lc_o, ll_o} <= ~{lu_o, lc_o, ll_o};
            end
        end
    end

    // Reset abandons any transfer in flight
    always @(negedge rst_n_i)
    begin
        disable serve;
        dv_o <= 1'b0;
        done_o <= 1'b0;
        lv_o <= 1'b0;
    end
endmodule : nand_flash_model

// [bench/test_nand_boot_search.sv]
// Self-checking bench for the NAND boot block search sequencer
`timescale 1ns/1ps
module test_nand_boot_search;
    localparam int FULL = 2 * 2 * 512;
    typedef struct {
        logic [31:0] bad;
        logic [31:0] p0;
        logic [2:0] c0;
        logic [2:0] cb;
        logic [2:0] c1;
        logic [2:0] st;
        logic [5:0] blk;
        int bytes;
    } row_t;
    row_t rows [8];
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mem_req_o, mem_mark_o, mem_data_valid_i, mem_done_i, mem_bad_i, syndrome_valid_o;
    logic loc_valid_i, loc_uncorrectable_i, out_valid_o, boot_done_o, boot_fail_o, boot_error_o;
    logic [5:0] mem_block_o, mem_page_o, last_blk, prev_pg;
    logic [1:0] mem_seg_o, prev_sg;
    logic [7:0] mem_data_i, out_data_o, next_ps;
    logic [79:0] mem_parity_i, mem_ecc_i, syndrome_o;
    logic [2:0] loc_count_i;
    logic [51:0] loc_list_i;
    logic prev_mark;
    int err_total = 0;
    int checked = 0;
    int bytes, nbyte, r;

    always #2 sys_clk_i = ~sys_clk_i;

    // Two pages of two segments keep each block short
    nand_boot_search #(.PAGES_PER_BLOCK(2), .SEGS_PER_PAGE(2)) DUT (
        .sys_clk_i, .reset_n_i, .mem_req_o, .mem_mark_o, .mem_block_o, .mem_page_o,
        .mem_seg_o, .mem_data_valid_i, .mem_data_i, .mem_done_i, .mem_bad_i,
        .mem_parity_i, .mem_ecc_i, .syndrome_valid_o, .syndrome_o, .loc_valid_i,
        .loc_uncorrectable_i, .loc_count_i, .loc_list_i, .out_valid_o, .out_data_o,
        .boot_done_o, .boot_fail_o, .boot_error_o);

    nand_flash_model flash (
        .clk_i(sys_clk_i), .rst_n_i(reset_n_i), .req_i(mem_req_o), .mark_i(mem_mark_o),
        .blk_i(mem_block_o), .pg_i(mem_page_o), .seg_i(mem_seg_o), .syn_i(syndrome_valid_o),
        .dv_o(mem_data_valid_i), .d_o(mem_data_i), .done_o(mem_done_i), .bad_o(mem_bad_i),
        .par_o(mem_parity_i), .ecc_o(mem_ecc_i), .lv_o(loc_valid_i),
        .lu_o(loc_uncorrectable_i), .lc_o(loc_count_i), .ll_o(loc_list_i));

    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic final_report;
        $display("mismatches %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Order of requests, syndrome and every corrected byte, seen at the clock edge
    always @(posedge sys_clk_i)
    begin
        if (reset_n_i !== 1'b1)
        begin
            last_blk = 6'h3f;
            prev_mark = 1'b0;
            bytes = 0;
        end
        else if (mem_req_o === 1'b1)
        begin
            nbyte = 0;
            next_ps = prev_sg == 2'h1 ? {prev_pg + 6'h01, 2'h0} : {prev_pg, prev_sg + 2'h1};
            if ({boot_done_o, boot_fail_o, boot_error_o} !== 3'h0) fail("late request"); else checked++;
            if (mem_mark_o === 1'b1)
            begin
                if (mem_block_o !== last_blk + 6'h01 || mem_block_o > 6'h1f) fail("block"); else checked++;
            end
            else if (prev_mark)
            begin
                if ({mem_block_o ^ last_blk, mem_page_o, mem_seg_o, flash.bad_mark[mem_block_o[4:0]]} !== 15'h0) fail("open"); else checked++;
            end
            else if ({mem_block_o ^ last_blk, mem_page_o, mem_seg_o} !== {6'h0, next_ps}) fail("page order"); else checked++;
            prev_mark = mem_mark_o;
            last_blk = mem_block_o;
            prev_pg = mem_page_o;
            prev_sg = mem_seg_o;
        end
        if (reset_n_i === 1'b1 && syndrome_valid_o === 1'b1)
            if (syndrome_o !== {mem_block_o, mem_page_o, mem_seg_o, 66'h0}) fail("syndrome"); else checked++;
        if (reset_n_i === 1'b1 && out_valid_o === 1'b1)
        begin
            if (out_data_o !== flash.pat(mem_block_o, mem_page_o, mem_seg_o, nbyte)) fail("byte"); else checked++;
            nbyte++;
            bytes++;
        end
    end

    // Loads the flash contents, resets, optionally resets again mid-stream, runs to a verdict
    task automatic run_row(input row_t rw, input logic slow, input logic abort);
        int n;
        int k;
        for (k = 0; k < 32; k++)
        begin
            flash.bad_mark[k] = rw.bad[k];
            flash.verdict[k][0] = rw.p0[k] ? rw.c0 : rw.cb;
            flash.verdict[k][1] = rw.c1;
        end
        flash.slow = slow;
        for (k = 0; k <= int'(abort); k++)
        begin
            @(negedge sys_clk_i);
            reset_n_i = 1'b0;
            repeat (6) @(negedge sys_clk_i);
            if ({mem_req_o, syndrome_valid_o, out_valid_o, boot_done_o, boot_fail_o, boot_error_o} !== 6'h0) fail("reset"); else checked++;
            reset_n_i = 1'b1;
            @(posedge sys_clk_i);
            #1;
            if ({mem_req_o, mem_mark_o, mem_block_o} !== 8'hc0) fail("first mark read"); else checked++;
            for (n = 0; n < 20000 && k < int'(abort) && bytes < 5; n++)
                @(negedge sys_clk_i);
        end
        for (n = 0; n < 30000 && {boot_error_o, boot_fail_o, boot_done_o} === 3'h0; n++)
            @(negedge sys_clk_i);
        repeat (40) @(negedge sys_clk_i);
        if ({boot_error_o, boot_fail_o, boot_done_o} !== rw.st) fail("verdict"); else checked++;
        if (mem_block_o !== rw.blk) fail("final block"); else checked++;
        if (bytes !== rw.bytes) fail("byte count"); else checked++;
    endtask : run_row

    initial
    begin
        // Bad marks, failing page-zero blocks, their code, other page-zero code, page-one code
        rows[0] = '{32'h0, 32'h0, 3'h0, 3'h0, 3'h0, 3'h1, 6'h00, FULL};
        rows[1] = '{32'h3, 32'h0, 3'h0, 3'h0, 3'h0, 3'h1, 6'h02, FULL};
        rows[2] = '{32'h0, 32'h1, 3'h2, 3'h1, 3'h0, 3'h1, 6'h01, FULL};
        rows[3] = '{32'h0, 32'h3, 3'h4, 3'h5, 3'h0, 3'h1, 6'h02, FULL};
        rows[4] = '{32'h0, 32'h1, 3'h3, 3'h0, 3'h3, 3'h4, 6'h01, FULL / 2};
        rows[5] = '{32'h0, 32'h0, 3'h0, 3'h0, 3'h2, 3'h4, 6'h00, FULL / 2};
        rows[6] = '{32'h5555_5555, 32'haaaa_aaaa, 3'h3, 3'h0, 3'h0, 3'h2, 6'h20, 0};
        rows[7] = '{32'h0, 32'h7fff_ffff, 3'h2, 3'h0, 3'h0, 3'h1, 6'h1f, FULL};
        for (r = 0; r < 8; r++)
            run_row(rows[r], r[0], 1'b0);
        // A reset in mid-stream must clear all outputs and restart at block 0
        run_row(rows[2], 1'b1, 1'b1);
        final_report();
    end

    // Cut a hang short well beyond the longest expected run
    initial
    begin
        #400000;
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule : test_nand_boot_search
